// file: pkg/evt_pkg.sv
// Constants shared by the event timer/counter block
package evt_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_TIMERS = 4;
    localparam int NUM_PINS   = 7;
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int SRC_W      = 4;
    localparam int NUM_CACHE  = 4;

    // ----------------------------------------------------------------
    // Register map, byte addresses relative to the block base
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] TMR_STRIDE  = 12'h020;
    localparam int                TMR_SEL_LSB = 5;
    localparam logic [4:0]        CTL_OFS     = 5'h00;
    localparam logic [4:0]        LIM_OFS     = 5'h04;
    localparam logic [4:0]        VAL_OFS     = 5'h08;
    localparam logic [ADDR_W-1:0] STAT_ADDR   = 12'h080;
    localparam logic [ADDR_W-1:0] CLR_ADDR    = 12'h084;
    localparam logic [ADDR_W-1:0] EN_ADDR     = 12'h088;
    localparam logic [ADDR_W-1:0] MEVT_ADDR   = 12'h08c;

    // ----------------------------------------------------------------
    // Control fields and reset values
    // ----------------------------------------------------------------
    localparam int               CTL_RUN_BIT  = 0;
    localparam int               CTL_SRC_LSB  = 4;
    localparam logic             CTL_RUN_RST  = 1'b0;
    localparam logic [SRC_W-1:0] CTL_SRC_RST  = 4'h0;
    localparam int               MEVT_SEL_W   = 2;
    localparam int               MEVT_ONE_LSB = 0;
    localparam int               MEVT_TWO_LSB = 8;
    localparam logic [3:0]       STAT_RST     = 4'h0;
    localparam logic [3:0]       EN_RST       = 4'h0;

    // ----------------------------------------------------------------
    // Event source codes
    // ----------------------------------------------------------------
    localparam logic [SRC_W-1:0] SRC_CPU_CLOCK   = 4'h0;
    localparam logic [SRC_W-1:0] SRC_DIVIDED     = 4'h1;
    localparam logic [SRC_W-1:0] SRC_COUNT_PIN   = 4'h2;
    localparam logic [SRC_W-1:0] SRC_DATA_BRK    = 4'h3;
    localparam logic [SRC_W-1:0] SRC_INSTR_BRK   = 4'h4;
    localparam logic [SRC_W-1:0] SRC_CACHE_ONE   = 4'h5;
    localparam logic [SRC_W-1:0] SRC_CACHE_TWO   = 4'h6;
    localparam logic [SRC_W-1:0] SRC_VIDEO_IN    = 4'h7;
    localparam logic [SRC_W-1:0] SRC_LAST_PIN    = 4'hc;

    // ----------------------------------------------------------------
    // Timing: divided clock period
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         DIV_PERIOD_NS  = 160;
    localparam int         DIV_CYCLES     = (DIV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] DIV_LAST       = 8'(DIV_CYCLES - 1);

endpackage : evt_pkg

// file: pkg/evt_tmr_if.sv
// Link between the register front end and one timer/counter
interface evt_tmr_if;
    import evt_pkg::*;
    logic              wr_ctl;
    logic              wr_lim;
    logic              wr_val;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        inc;
    logic              run;
    logic [SRC_W-1:0]  src;
    logic [DATA_W-1:0] limit;
    logic [DATA_W-1:0] value;
    logic              irq;

    modport front (output wr_ctl, wr_lim, wr_val, wdata, inc,
                   input  run, src, limit, value, irq);
    modport cnt   (input  wr_ctl, wr_lim, wr_val, wdata, inc,
                   output run, src, limit, value, irq);
endinterface : evt_tmr_if

// file: hdl/evt_edge_sync.sv
// Pin synchronisers with rising-edge detection
module evt_edge_sync import evt_pkg::*; (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [NUM_PINS-1:0] pins,
    output logic      [NUM_PINS-1:0] rise
);
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] sync;
    logic [NUM_PINS-1:0] last;

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        always_ff @(posedge clk) begin
            if (!resetn) begin
                meta[p] <= 1'b0;
                sync[p] <= 1'b0;
                last[p] <= 1'b0;
                rise[p] <= 1'b0;
            end else begin
                meta[p] <= pins[p];
                sync[p] <= meta[p];
                last[p] <= sync[p];
                rise[p] <= sync[p] & ~last[p];
            end
        end

        pin_rise_a: assert property (@(posedge clk) disable iff (!resetn)
            rise[p] |-> $past(sync[p]) && !$past(last[p]))
            else $error("edge pulse without a rising edge");
    end

endmodule : evt_edge_sync

// file: hdl/evt_counter.sv
// One timer/counter: control, wrap limit, count value and wrap request
module evt_counter import evt_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    evt_tmr_if.cnt   tif
);
    logic [DATA_W:0] sum;
    logic [DATA_W:0] lim_ext;
    logic            wrap;
    logic            store;

    // Zero limit behaves as two to the 32
    assign lim_ext = (tif.limit == '0) ? {1'b1, {DATA_W{1'b0}}}
                                       : {1'b0, tif.limit};
    assign sum     = {1'b0, tif.value} + {{(DATA_W-1){1'b0}}, tif.inc};
    assign store   = tif.wr_val | tif.wr_lim;
    // Only crossing the limit from below wraps; a value already at or
    // above it runs on through the full range first
    assign wrap    = tif.run && (tif.inc != 2'h0)
                     && ({1'b0, tif.value} < lim_ext) && (sum >= lim_ext);

    // ----------------------------------------------------------------
    // Control
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tif.run <= CTL_RUN_RST;
            tif.src <= CTL_SRC_RST;
        end else if (tif.wr_ctl) begin
            tif.run <= tif.wdata[CTL_RUN_BIT];
            tif.src <= tif.wdata[CTL_SRC_LSB +: SRC_W];
        end
    end

    // ----------------------------------------------------------------
    // Limit and value (no reset: undefined until software loads them)
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (tif.wr_lim) begin
            tif.limit <= tif.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (tif.wr_val) begin
            tif.value <= tif.wdata;
        end else if (wrap) begin
            tif.value <= DATA_W'(sum - lim_ext);
        end else if (tif.run) begin
            tif.value <= sum[DATA_W-1:0];
        end
    end

    // One-cycle request per wrap, never on a software store
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tif.irq <= 1'b0;
        end else begin
            tif.irq <= wrap && !store;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    wrap_value_a: assert property (@(posedge clk) disable iff (!resetn)
        tif.irq |-> tif.value <= 32'h1 && $past(tif.run))
        else $error("wrap request without wrap to zero or one");

    stop_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !tif.run && !tif.wr_val |=> $stable(tif.value))
        else $error("stopped counter moved");

    step_size_a: assert property (@(posedge clk) disable iff (!resetn)
        tif.run && !tif.wr_val && !wrap |=> (tif.value - $past(tif.value)) <= 32'h2)
        else $error("counter stepped by more than two");

    lim_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        tif.wr_lim && !tif.wr_val && !tif.run |=> $stable(tif.value))
        else $error("limit write disturbed the value");

    store_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        store |=> !tif.irq)
        else $error("request after a software store");

    zero_limit_a: assert property (@(posedge clk) disable iff (!resetn)
        tif.run && tif.limit == '0 && tif.value == 32'hffffffff && tif.inc == 2'h1
        && !store |=> tif.irq && tif.value == '0)
        else $error("zero limit did not wrap after full range");

    reset_stop_a: assert property (@(posedge clk)
        !resetn |=> !tif.run && tif.src == CTL_SRC_RST && !tif.irq)
        else $error("control not cleared by reset");

endmodule : evt_counter

// file: hdl/evt_timers.sv
// Four event timer/counters with register port and interrupt status
//
// Contract
// - four identical timers, last reserved for system
// - source field picks event; 13-15 count nothing
// - data breakpoints add up to two
// - pin sources count rising edges, synchronised
// - cache sources follow memory event select
// - crossing limit wraps to 0/1, requests
// - requests need no acknowledge at timer
// - counting only while run bit set
// - limit write leaves count value alone
// - store reaching limit raises no request
// - zero limit means two to the 32
// - reset clears control; limit, value undefined
// - three registers per timer, 0x20 stride
module evt_timers import evt_pkg::*; (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [DATA_W-1:0]    wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [DATA_W-1:0]    rdata,
    input  wire logic                 count_pin,
    input  wire logic                 video_input_clock_pin,
    input  wire logic                 video_output_clock_pin,
    input  wire logic                 audio_input_word_strobe,
    input  wire logic                 audio_output_word_strobe,
    input  wire logic                 serial_rx_frame_sync,
    input  wire logic                 serial_tx_frame_sync,
    input  wire logic [1:0]           data_breakpoint_event,
    input  wire logic                 instruction_breakpoint_event,
    input  wire logic [NUM_CACHE-1:0] cache_perf_event,
    output logic      [NUM_TIMERS-1:0] timer_irq,
    output logic                      irq
);
    evt_tmr_if tif [NUM_TIMERS] ();

    logic [NUM_PINS-1:0]   rise;
    logic [7:0]            div_cnt;
    logic                  divided_cpu_clock;
    logic [MEVT_SEL_W-1:0] cache_sel_one;
    logic [MEVT_SEL_W-1:0] cache_sel_two;
    logic                  cache_event_one;
    logic                  cache_event_two;
    logic [NUM_TIMERS-1:0] status;
    logic [NUM_TIMERS-1:0] enable;
    logic [NUM_TIMERS-1:0] next_status;
    logic [NUM_TIMERS-1:0] wrap_vec;
    logic [NUM_TIMERS-1:0] clr_mask;
    logic [1:0]            dbrk_sum;

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    evt_edge_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .pins   ({serial_tx_frame_sync, serial_rx_frame_sync, audio_output_word_strobe,
                  audio_input_word_strobe, video_output_clock_pin, video_input_clock_pin,
                  count_pin}),
        .rise   (rise)
    );

    // Divided clock is a one-cycle enable, not a second clock
    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_cnt           <= 8'h00;
            divided_cpu_clock <= 1'b0;
        end else begin
            divided_cpu_clock <= (div_cnt == DIV_LAST);
            div_cnt           <= (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
        end
    end

    assign cache_event_one = cache_perf_event[cache_sel_one];
    assign cache_event_two = cache_perf_event[cache_sel_two];
    assign dbrk_sum = {1'b0, data_breakpoint_event[0]} + {1'b0, data_breakpoint_event[1]};

    function automatic logic [1:0] evt_step(input logic [SRC_W-1:0] src);
        logic [1:0] step;
        step = 2'h0;
        if (src == SRC_CPU_CLOCK) begin
            step = 2'h1;
        end else if (src == SRC_DIVIDED) begin
            step = {1'b0, divided_cpu_clock};
        end else if (src == SRC_COUNT_PIN) begin
            step = {1'b0, rise[0]};
        end else if (src == SRC_DATA_BRK) begin
            step = dbrk_sum;
        end else if (src == SRC_INSTR_BRK) begin
            step = {1'b0, instruction_breakpoint_event};
        end else if (src == SRC_CACHE_ONE) begin
            step = {1'b0, cache_event_one};
        end else if (src == SRC_CACHE_TWO) begin
            step = {1'b0, cache_event_two};
        end else if (src >= SRC_VIDEO_IN && src <= SRC_LAST_PIN) begin
            step = {1'b0, rise[3'(src - SRC_VIDEO_IN) + 3'h1]};
        end
        return step;
    endfunction : evt_step

    // ----------------------------------------------------------------
    // Timers (the last one is the system-reserved timer)
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
        logic hit;
        assign hit = wr && (addr[ADDR_W-1:TMR_SEL_LSB] == (ADDR_W-TMR_SEL_LSB)'(i));
        assign tif[i].wr_ctl = hit && (addr[TMR_SEL_LSB-1:0] == CTL_OFS);
        assign tif[i].wr_lim = hit && (addr[TMR_SEL_LSB-1:0] == LIM_OFS);
        assign tif[i].wr_val = hit && (addr[TMR_SEL_LSB-1:0] == VAL_OFS);
        assign tif[i].wdata  = wdata;
        // Process form so the step follows the event inputs the function reads
        always_comb begin
            tif[i].inc = evt_step(tif[i].src);
        end
        assign wrap_vec[i]   = tif[i].irq;
        assign timer_irq[i]  = tif[i].irq;

        evt_counter u_cnt (
            .clk    (clk),
            .resetn (resetn),
            .tif    (tif[i])
        );

        undef_src_a: assert property (@(posedge clk) disable iff (!resetn)
            tif[i].src > SRC_LAST_PIN |-> tif[i].inc == 2'h0)
            else $error("undefined source produced a count");
    end

    // ----------------------------------------------------------------
    // Interrupt status, clear, enable
    // ----------------------------------------------------------------
    assign clr_mask = (wr && addr == CLR_ADDR) ? wdata[NUM_TIMERS-1:0] : '0;
    // A wrap in the clear cycle survives the clear
    assign next_status = (status & ~clr_mask) | wrap_vec;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status <= STAT_RST;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & enable_next());
        end
    end

    function automatic logic [NUM_TIMERS-1:0] enable_next();
        return (wr && addr == EN_ADDR) ? wdata[NUM_TIMERS-1:0] : enable;
    endfunction : enable_next

    always_ff @(posedge clk) begin
        if (!resetn) begin
            enable <= EN_RST;
        end else begin
            enable <= enable_next();
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cache_sel_one <= '0;
            cache_sel_two <= '0;
        end else if (wr && addr == MEVT_ADDR) begin
            cache_sel_one <= wdata[MEVT_ONE_LSB +: MEVT_SEL_W];
            cache_sel_two <= wdata[MEVT_TWO_LSB +: MEVT_SEL_W];
        end
    end

    // ----------------------------------------------------------------
    // Read port: data one cycle after the strobe, zero otherwise
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= '0;
        end else begin
            rdata <= '0;
            if (rd) begin
                if (addr == STAT_ADDR) begin
                    rdata <= {{(DATA_W-NUM_TIMERS){1'b0}}, status};
                end else if (addr == EN_ADDR) begin
                    rdata <= {{(DATA_W-NUM_TIMERS){1'b0}}, enable};
                end else if (addr == MEVT_ADDR) begin
                    rdata <= {{(DATA_W-MEVT_TWO_LSB-MEVT_SEL_W){1'b0}}, cache_sel_two,
                              {(MEVT_TWO_LSB-MEVT_SEL_W){1'b0}}, cache_sel_one};
                end
                for (int k = 0; k < NUM_TIMERS; k++) begin
                    if (addr[ADDR_W-1:TMR_SEL_LSB] == (ADDR_W-TMR_SEL_LSB)'(k)) begin
                        if (addr[TMR_SEL_LSB-1:0] == CTL_OFS) begin
                            rdata <= {{(DATA_W-CTL_SRC_LSB-SRC_W){1'b0}}, g_src(k),
                                      {(CTL_SRC_LSB-1){1'b0}}, g_run(k)};
                        end else if (addr[TMR_SEL_LSB-1:0] == LIM_OFS) begin
                            rdata <= g_lim(k);
                        end else if (addr[TMR_SEL_LSB-1:0] == VAL_OFS) begin
                            rdata <= g_val(k);
                        end
                    end
                end
            end
        end
    end

    // Flattened views so the read loop can index the interface array
    logic [NUM_TIMERS-1:0]             run_vec;
    logic [NUM_TIMERS-1:0][SRC_W-1:0]  src_vec;
    logic [NUM_TIMERS-1:0][DATA_W-1:0] lim_vec;
    logic [NUM_TIMERS-1:0][DATA_W-1:0] val_vec;
    for (genvar j = 0; j < NUM_TIMERS; j++) begin : g_view
        assign run_vec[j] = tif[j].run;
        assign src_vec[j] = tif[j].src;
        assign lim_vec[j] = tif[j].limit;
        assign val_vec[j] = tif[j].value;
    end

    function automatic logic g_run(input int k);
        return run_vec[k];
    endfunction : g_run
    function automatic logic [SRC_W-1:0] g_src(input int k);
        return src_vec[k];
    endfunction : g_src
    function automatic logic [DATA_W-1:0] g_lim(input int k);
        return lim_vec[k];
    endfunction : g_lim
    function automatic logic [DATA_W-1:0] g_val(input int k);
        return val_vec[k];
    endfunction : g_val

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    clear_race_a: assert property (@(posedge clk) disable iff (!resetn)
        (|wrap_vec) && wr && addr == CLR_ADDR
        |=> (status & $past(wrap_vec)) == $past(wrap_vec))
        else $error("clear swallowed a same-cycle wrap");

    irq_level_a: assert property (@(posedge clk) disable iff (!resetn)
        irq == |(status & enable))
        else $error("interrupt level disagrees with status and enable");

endmodule : evt_timers

// file: test/evt_far_model.sv
// Far-side model: asynchronous event pins and edge-mode request latch
module evt_far_model import evt_pkg::*; (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic [NUM_TIMERS-1:0] timer_irq,
    output logic      [NUM_PINS-1:0]   pins,
    output logic      [NUM_TIMERS-1:0] pending
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;
    // Edge mode: a one-cycle request stays pending; dispatch not modelled
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pending <= '0;
        end else begin
            pending <= pending | timer_irq;
        end
    end
    // Off-grid high time; the 70 ns pulse period keeps every rising edge at the same clock phase
    task automatic pulse_pin(input int idx, input int n);
        repeat (n) begin
            #33 pins[idx] = 1'b1;
            #37 pins[idx] = 1'b0;
        end
    endtask : pulse_pin
endmodule : evt_far_model

// file: test/test_evt_timers.sv
// Self-checking bench for the event timer/counter block
module test_evt_timers import evt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk, resetn, wr, rd, ibk, hit;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata, rdata, got, v;
    logic [1:0]            dbk;
    logic [NUM_CACHE-1:0]  cev;
    logic [NUM_PINS-1:0]   pins;
    logic [NUM_TIMERS-1:0] timer_irq, pending;
    logic                  irq;
    int                    miscompares, n_checks, cyc;
    logic [ADDR_W-1:0] zr[8] = '{12'h000, 12'h020, 12'h040, 12'h060,
                                STAT_ADDR, CLR_ADDR, EN_ADDR, MEVT_ADDR};
    logic [SRC_W-1:0]  srcs[6] = '{SRC_INSTR_BRK, SRC_CACHE_ONE, SRC_CACHE_TWO,
                                  SRC_CACHE_TWO, 4'hd, 4'hf};
    logic [3:0]        cevs[6] = '{4'h0, 4'h4, 4'h4, 4'h2, 4'hf, 4'hf};
    logic [31:0]       exps[6] = '{32'h6, 32'h6, 32'h0, 32'h6, 32'h0, 32'h0};

    evt_timers uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .count_pin(pins[0]), .video_input_clock_pin(pins[1]),
        .video_output_clock_pin(pins[2]), .audio_input_word_strobe(pins[3]),
        .audio_output_word_strobe(pins[4]), .serial_rx_frame_sync(pins[5]),
        .serial_tx_frame_sync(pins[6]), .data_breakpoint_event(dbk),
        .instruction_breakpoint_event(ibk), .cache_perf_event(cev),
        .timer_irq(timer_irq), .irq(irq));
    evt_far_model far (.clk(clk), .resetn(resetn), .timer_irq(timer_irq), .pins(pins),
        .pending(pending));

    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // Read data stands only in the cycle after the strobe
    task automatic rreg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        got = rdata;
    endtask : rreg
    function automatic logic [ADDR_W-1:0] ta(input int t, input logic [4:0] ofs);
        return TMR_STRIDE * ADDR_W'(t) + ADDR_W'(ofs);
    endfunction : ta
    task automatic load(input int t, input logic [3:0] src, input logic [31:0] lim, val);
        wreg(ta(t, CTL_OFS), 32'h0);
        wreg(ta(t, LIM_OFS), lim);
        wreg(ta(t, VAL_OFS), val);
        wreg(ta(t, CTL_OFS), (32'(src) << CTL_SRC_LSB) | (32'h1 << CTL_RUN_BIT));
    endtask : load
    task automatic stop_read(input int t);
        wreg(ta(t, CTL_OFS), 32'h0);
        rreg(ta(t, VAL_OFS));
    endtask : stop_read
    task automatic wait_irq(input int t, input int lim);
        cyc = 0;
        while (timer_irq[t] !== 1'b1) begin
            @(negedge clk);
            cyc++;
            if (cyc > lim) begin
                chk("irq wait", 32'h1, 32'h0);
                tally_and_finish();
            end
        end
    endtask : wait_irq
    task automatic burst(input int n, input logic [1:0] d, input logic i, input logic [3:0] c);
        @(posedge clk);
        dbk <= d;
        ibk <= i;
        cev <= c;
        repeat (n) @(posedge clk);
        dbk <= '0;
        ibk <= 1'b0;
        cev <= '0;
    endtask : burst

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        chk("run length", 32'h0, 32'h1);
        tally_and_finish();
    end
    initial begin
        {resetn, wr, rd, ibk, dbk, cev, addr, wdata} = '0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        foreach (zr[k]) begin
            rreg(zr[k]);
            chk("reset value", 32'h0, got);
        end
        for (int t = 0; t < NUM_TIMERS; t++) wreg(ta(t, LIM_OFS), 32'h100 + 32'(t));
        for (int t = 0; t < NUM_TIMERS; t++) begin
            rreg(ta(t, LIM_OFS));
            chk("limit map", 32'h100 + 32'(t), got);
        end
        wreg(12'h0fc, 32'hffffffff);
        rreg(12'h0fc);
        chk("unmapped", 32'h0, got);
        // Wrap period, pulse width, status, level output
        wreg(EN_ADDR, 32'h1);
        load(0, SRC_CPU_CLOCK, 32'h5, 32'h3);
        wait_irq(0, 20);
        @(negedge clk);
        chk("request width", 32'h0, 32'(timer_irq[0]));
        wait_irq(0, 20);
        chk("wrap period", 32'h5, 32'(cyc + 1));
        chk("level irq", 32'h1, 32'(irq));
        chk("latched", 32'h1, 32'(pending[0]));
        stop_read(0);
        v = got;
        repeat (6) @(posedge clk);
        rreg(ta(0, VAL_OFS));
        chk("stopped hold", v, got);
        wreg(ta(0, LIM_OFS), 32'h40);
        rreg(ta(0, VAL_OFS));
        chk("limit keeps value", v, got);
        wreg(CLR_ADDR, 32'h1);
        rreg(STAT_ADDR);
        chk("status cleared", 32'h0, got & 32'h1);
        chk("irq dropped", 32'h0, 32'(irq));
        // Last wrap request lands in the clear cycle: the set must win
        load(0, SRC_CPU_CLOCK, 32'h1, 32'h0);
        @(posedge clk);
        addr  <= ta(0, CTL_OFS);
        wdata <= 32'h0;
        wr    <= 1'b1;
        @(posedge clk);
        addr  <= CLR_ADDR;
        wdata <= 32'h1;
        @(posedge clk);
        wr    <= 1'b0;
        rreg(STAT_ADDR);
        chk("set beats clear", 32'h1, got & 32'h1);
        // Store reaching the limit must not request
        load(1, SRC_CPU_CLOCK, 32'h7, 32'h7);
        hit = 1'b0;
        repeat (30) begin
            @(negedge clk);
            hit = hit | timer_irq[1];
        end
        chk("no store request", 32'h0, 32'(hit));
        load(2, SRC_CPU_CLOCK, 32'h0, 32'hfffffffd);
        wait_irq(2, 10);
        // Double steps, wrap to one
        load(3, SRC_DATA_BRK, 32'h9, 32'h0);
        burst(4, 2'b11, 1'b0, 4'h0);
        burst(1, 2'b11, 1'b0, 4'h0);
        burst(2, 2'b01, 1'b0, 4'h0);
        stop_read(3);
        chk("double step", 32'h3, got);
        rreg(STAT_ADDR);
        chk("system timer status", 32'h8, got & 32'h8);
        wreg(MEVT_ADDR, 32'h102);
        foreach (srcs[k]) begin
            load(1, srcs[k], 32'h0, 32'h0);
            burst(6, 2'b11, 1'b1, cevs[k]);
            stop_read(1);
            chk("source select", exps[k], got);
        end
        for (int p = 0; p < NUM_PINS; p++) begin
            load(1, (p == 0) ? SRC_COUNT_PIN : SRC_VIDEO_IN + 4'(p - 1), 32'h0, 32'h0);
            far.pulse_pin(p, 3);
            repeat (8) @(posedge clk);
            stop_read(1);
            chk("pin edges", 32'h3, got);
        end
        load(1, SRC_DIVIDED, 32'h0, 32'h0);
        repeat (160) @(posedge clk);
        stop_read(1);
        chk("divided clock", 32'h1, 32'(got >= 32'h9 && got <= 32'hb));
        tally_and_finish();
    end
endmodule : test_evt_timers
